// File: inc/dac_defines.svh
// register offsets, field positions and reset values of the channel address block
`ifndef DAC_DEFINES_SVH
`define DAC_DEFINES_SVH

`define DAC_AW            24
`define DAC_OFS_MEM_PTR   8'h04
`define DAC_OFS_MEM_LIM   8'h08
`define DAC_OFS_DEV_PTR   8'h0C
`define DAC_OFS_CTRL      8'h10
`define DAC_OFS_IRQ_STS   8'h14
`define DAC_OFS_IRQ_EN    8'h18
`define DAC_OFS_IRQ_CLR   8'h1C

`define DAC_B_ABORT       25
`define DAC_B_GO          24
`define DAC_B_SIZE_HI     22
`define DAC_B_SIZE_LO     20
`define DAC_B_HW_OFF      19
`define DAC_B_LOCK        18
`define DAC_B_INC_DEV     17
`define DAC_B_INC_MEM     16
`define DAC_B_SEL_HI      15
`define DAC_B_SEL_LO      9
`define DAC_B_DIR         8
`define DAC_B_BUSY        5

`define DAC_NSTS          3
`define DAC_S_DONE        0
`define DAC_S_TERM        1
`define DAC_S_ABORT       2

`define DAC_RST_PTR       24'h000000
`define DAC_RST_SIZE      3'h0
`define DAC_RST_SEL       7'h00
`define DAC_RST_STS       3'h0
`define DAC_RST_WORD      32'h00000000

`endif

// File: inc/dac_pkg.sv
// types of the channel address block
package dac_pkg;

  typedef enum logic [1:0]
  {
    DAC_IDLE = 2'b00,
    DAC_WAIT = 2'b01,
    DAC_MOVE = 2'b10
  } dac_state_t;

  typedef struct packed
  {
    dac_state_t  st;
    logic [23:0] mem_ptr;
    logic [23:0] mem_lim;
    logic [23:0] dev_ptr;
    logic        abort;
    logic        go;
    logic [2:0]  size;
    logic        hw_off;
    logic        lock;
    logic        inc_dev;
    logic        inc_mem;
    logic [6:0]  sel;
    logic        dir;
    logic [2:0]  sts;
    logic [2:0]  ien;
    logic [31:0] prdata;
    logic        pkt_req;
    logic        fc_done;
  } dac_regs_t;

endpackage

// File: src/dac_step.sv
// pointer step: adds the packet size when auto-increment is on
`timescale 1ns/1ps
`include "dac_defines.svh"

module dac_step
  import dac_pkg::*;
(
  input  wire logic [23:0] ptr,
  input  wire logic [2:0]  size,
  input  wire logic        inc,
  output logic      [23:0] next_ptr
);

  // wraps at the top of the 24-bit space, as the bus address does
  assign next_ptr = inc ? ptr + {21'h000000, size} : ptr;

endmodule

// File: src/dac_channel.sv
// one dma channel: address limit, peripheral pointer and upper control fields
`timescale 1ns/1ps
`include "dac_defines.svh"

module dac_channel
  import dac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pkt_req,
  input  wire logic        pkt_ack,
  output logic      [23:0] pkt_mem_addr,
  output logic      [23:0] pkt_dev_addr,
  output logic      [2:0]  pkt_size,
  output logic             pkt_dir,
  output logic             pkt_lock,
  output logic      [6:0]  fc_sel,
  input  wire logic        fc_req,
  input  wire logic        fc_term,
  output logic             fc_done,
  output logic             busy,
  output logic             irq
);

  dac_regs_t   r;
  dac_regs_t   next_r;
  logic [23:0] next_mem;
  logic [23:0] next_dev;
  logic        wr;
  logic        rd_setup;
  logic        mapped;
  logic        hw_req;
  logic        hw_term;
  logic        limit_hit;
  logic [2:0]  sts_set;
  logic [2:0]  sts_clr;
  logic [31:0] ctrl_word;

  dac_step u_mem_step
  (
    .ptr      (r.mem_ptr),
    .size     (r.size),
    .inc      (r.inc_mem),
    .next_ptr (next_mem)
  );

  dac_step u_dev_step
  (
    .ptr      (r.dev_ptr),
    .size     (r.size),
    .inc      (r.inc_dev),
    .next_ptr (next_dev)
  );

  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb
  begin
    if (paddr == `DAC_OFS_MEM_PTR)
      mapped = 1'b1;
    else if (paddr == `DAC_OFS_MEM_LIM)
      mapped = 1'b1;
    else if (paddr == `DAC_OFS_DEV_PTR)
      mapped = 1'b1;
    else if (paddr == `DAC_OFS_CTRL)
      mapped = 1'b1;
    else if (paddr == `DAC_OFS_IRQ_STS)
      mapped = 1'b1;
    else if (paddr == `DAC_OFS_IRQ_EN)
      mapped = 1'b1;
    else if (paddr == `DAC_OFS_IRQ_CLR)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign hw_req  = fc_req & ~r.hw_off;
  assign hw_term = fc_term & ~r.hw_off;

  // limit only counts with memory increment
  assign limit_hit = r.inc_mem & (next_mem == r.mem_lim);

  // reserved control bits assembled as zero
  always_comb
  begin
    ctrl_word                                 = `DAC_RST_WORD;
    ctrl_word[`DAC_B_ABORT]                   = r.abort;
    ctrl_word[`DAC_B_GO]                      = r.go;
    ctrl_word[`DAC_B_SIZE_HI:`DAC_B_SIZE_LO]  = r.size;
    ctrl_word[`DAC_B_HW_OFF]                  = r.hw_off;
    ctrl_word[`DAC_B_LOCK]                    = r.lock;
    ctrl_word[`DAC_B_INC_DEV]                 = r.inc_dev;
    ctrl_word[`DAC_B_INC_MEM]                 = r.inc_mem;
    ctrl_word[`DAC_B_SEL_HI:`DAC_B_SEL_LO]    = r.sel;
    ctrl_word[`DAC_B_DIR]                     = r.dir;
    ctrl_word[`DAC_B_BUSY]                    = (r.st != DAC_IDLE);
  end

  always_comb
  begin
    next_r         = r;
    next_r.fc_done = 1'b0;
    sts_set        = `DAC_RST_STS;
    sts_clr        = `DAC_RST_STS;

    case (r.st)
      DAC_IDLE:
      begin
        if (!r.abort && r.hw_off && r.go)
        begin
          next_r.st      = DAC_MOVE;
          next_r.pkt_req = 1'b1;
        end
        else if (!r.abort && hw_req)
        begin
          next_r.st      = DAC_MOVE;
          next_r.pkt_req = 1'b1;
        end
      end
      DAC_WAIT:
      begin
        if (hw_term)
        begin
          next_r.st                = DAC_IDLE;
          sts_set[`DAC_S_TERM]     = 1'b1;
        end
        else if (hw_req)
        begin
          next_r.st      = DAC_MOVE;
          next_r.pkt_req = 1'b1;
        end
      end
      DAC_MOVE:
      begin
        if (pkt_ack)
        begin
          next_r.mem_ptr = next_mem;
          next_r.dev_ptr = next_dev;
          next_r.pkt_req = 1'b0;
          next_r.fc_done = ~r.hw_off;
          if (limit_hit)
          begin
            next_r.st            = DAC_IDLE;
            next_r.go            = 1'b0;
            sts_set[`DAC_S_DONE] = 1'b1;
          end
          else if (hw_term)
          begin
            next_r.st            = DAC_IDLE;
            sts_set[`DAC_S_TERM] = 1'b1;
          end
          else if (r.hw_off)
          begin
            // firmware flow keeps moving until the limit is hit or an abort, whatever go holds
            next_r.st      = DAC_MOVE;
            next_r.pkt_req = 1'b1;
          end
          else
          begin
            next_r.st = DAC_WAIT;
          end
        end
      end
      default:
      begin
        next_r.st      = DAC_IDLE;
        next_r.pkt_req = 1'b0;
      end
    endcase

    if (r.abort && (r.st != DAC_IDLE))
    begin
      next_r.st             = DAC_IDLE;
      next_r.pkt_req        = 1'b0;
      next_r.go             = 1'b0;
      sts_set               = `DAC_RST_STS;
      sts_set[`DAC_S_ABORT] = 1'b1;
    end

    if (wr)
    begin
      if (paddr == `DAC_OFS_MEM_PTR)
        next_r.mem_ptr = pwdata[`DAC_AW-1:0];
      else if (paddr == `DAC_OFS_MEM_LIM)
        next_r.mem_lim = pwdata[`DAC_AW-1:0];
      else if (paddr == `DAC_OFS_DEV_PTR)
        next_r.dev_ptr = pwdata[`DAC_AW-1:0];
      else if (paddr == `DAC_OFS_CTRL)
      begin
        // reserved and busy bits not stored
        next_r.abort   = pwdata[`DAC_B_ABORT];
        next_r.go      = pwdata[`DAC_B_GO];
        next_r.size    = pwdata[`DAC_B_SIZE_HI:`DAC_B_SIZE_LO];
        next_r.hw_off  = pwdata[`DAC_B_HW_OFF];
        next_r.lock    = pwdata[`DAC_B_LOCK];
        next_r.inc_dev = pwdata[`DAC_B_INC_DEV];
        next_r.inc_mem = pwdata[`DAC_B_INC_MEM];
        next_r.sel     = pwdata[`DAC_B_SEL_HI:`DAC_B_SEL_LO];
        next_r.dir     = pwdata[`DAC_B_DIR];
      end
      else if (paddr == `DAC_OFS_IRQ_EN)
        next_r.ien = pwdata[`DAC_NSTS-1:0];
      else if (paddr == `DAC_OFS_IRQ_CLR)
        sts_clr = pwdata[`DAC_NSTS-1:0];
    end

    // hardware set wins over a clear in the same cycle
    next_r.sts = (r.sts & ~sts_clr) | sts_set;

    if (rd_setup)
    begin
      if (paddr == `DAC_OFS_MEM_PTR)
        next_r.prdata = {8'h00, r.mem_ptr};
      else if (paddr == `DAC_OFS_MEM_LIM)
        next_r.prdata = {8'h00, r.mem_lim};
      else if (paddr == `DAC_OFS_DEV_PTR)
        next_r.prdata = {8'h00, r.dev_ptr};
      else if (paddr == `DAC_OFS_CTRL)
        next_r.prdata = ctrl_word;
      else if (paddr == `DAC_OFS_IRQ_STS)
        next_r.prdata = {29'h00000000, r.sts};
      else if (paddr == `DAC_OFS_IRQ_EN)
        next_r.prdata = {29'h00000000, r.ien};
      else
        next_r.prdata = `DAC_RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r.st      <= DAC_IDLE;
      r.mem_ptr <= `DAC_RST_PTR;
      r.mem_lim <= `DAC_RST_PTR;
      r.dev_ptr <= `DAC_RST_PTR;
      r.abort   <= 1'b0;
      r.go      <= 1'b0;
      r.size    <= `DAC_RST_SIZE;
      r.hw_off  <= 1'b0;
      r.lock    <= 1'b0;
      r.inc_dev <= 1'b0;
      r.inc_mem <= 1'b0;
      r.sel     <= `DAC_RST_SEL;
      r.dir     <= 1'b0;
      r.sts     <= `DAC_RST_STS;
      r.ien     <= `DAC_RST_STS;
      r.prdata  <= `DAC_RST_WORD;
      r.pkt_req <= 1'b0;
      r.fc_done <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = r.prdata;

  assign pkt_req      = r.pkt_req;
  assign pkt_mem_addr = r.mem_ptr;
  // peripheral side addressed by its pointer
  assign pkt_dev_addr = r.dev_ptr;
  assign pkt_size     = r.size;
  assign pkt_dir      = r.dir;
  assign pkt_lock     = r.lock;
  assign fc_sel       = r.sel;
  assign fc_done      = r.fc_done;
  assign busy         = (r.st != DAC_IDLE);
  assign irq          = |(r.sts & r.ien);

endmodule

// File: tb/dac_partner.sv
// transfer engine model acking packet requests
`timescale 1ns/1ps
module dac_partner
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pkt_req,
  input  wire logic [1:0] lag,
  output logic            pkt_ack
);
  logic [1:0] cnt;
  // slow answers wait lag cycles
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt     <= 2'h0;
      pkt_ack <= 1'b0;
    end
    else
    begin
      pkt_ack <= pkt_req && !pkt_ack && cnt == lag;
      cnt     <= (pkt_req && !pkt_ack && cnt != lag) ? cnt + 2'h1 : 2'h0;
    end
endmodule

// File: tb/dac_channel_asserts.sv
// port assertions of the channel address block
`timescale 1ns/1ps
module dac_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pkt_req,
  input wire logic        pkt_ack,
  input wire logic        fc_req,
  input wire logic        fc_term,
  input wire logic        busy,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [23:0] pkt_mem_addr,
  input wire logic [23:0] pkt_dev_addr,
  input wire logic [2:0]  pkt_size
);
  logic        im, idv, ho, ab;
  logic [23:0] lim, ms, ds;
  wire         wr = psel && penable && pwrite;
  wire         rd = psel && !penable && !pwrite;
  // software pointer writes and aborts make the step unknowable
  wire         ok = pkt_req && pkt_ack && !wr && !ab && (ho || !fc_term);
  assign ms = pkt_mem_addr + (im ? pkt_size : 3'h0);
  assign ds = pkt_dev_addr + (idv ? pkt_size : 3'h0);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {ab, ho, idv, im} <= 4'h0;
      lim               <= 24'h000000;
    end
    else if (wr && paddr == 8'h10)
      {ab, ho, idv, im} <= {pwdata[25], pwdata[19], pwdata[17], pwdata[16]};
    else if (wr && paddr == 8'h08)
      lim <= pwdata[23:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go;
    wr && paddr == 8'h10 && pwdata[24] && pwdata[19] && !pwdata[25] && !busy;
  endsequence
  sequence s_last;
    ok && im && ms == lim;
  endsequence
  a_go_start: assert property (s_go |-> ##[1:3] pkt_req)
    else $error("no start");
  a_limit_end: assert property (s_last |=> !busy && !pkt_req)
    else $error("no end at limit");
  a_mem_step: assert property (ok |=> pkt_mem_addr == $past(ms))
    else $error("bad memory step");
  a_dev_step: assert property (ok |=> pkt_dev_addr == $past(ds))
    else $error("bad device step");
  a_no_self_end: assert property (ok && !im |=> busy)
    else $error("ended itself");
  a_abort_stop: assert property (ab && busy && !wr |=> !busy && !pkt_req)
    else $error("abort ignored");
  a_hw_ignore: assert property (!busy && ho && fc_req && !wr && !$past(wr) |=> !busy)
    else $error("request heeded");
  a_dev_read: assert property (rd && paddr == 8'h0C |=> prdata == {8'h00, $past(pkt_dev_addr)})
    else $error("bad device pointer");
  a_rsvd_zero: assert property (rd && paddr == 8'h10 |=> prdata[31:26] == 6'h00 && !prdata[23])
    else $error("reserved bits set");
endmodule
bind dac_channel dac_chk i_dac_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pkt_req, .pkt_ack, .fc_req,
  .fc_term, .busy, .paddr, .pwdata, .prdata, .pkt_mem_addr, .pkt_dev_addr, .pkt_size);

// File: tb/dac_channel_address_control_bench.sv
// bench of the channel address block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module dac_channel_address_control_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fc_req = 0, fc_term = 0, ei = 0;
  logic        pkt_req, pkt_ack, fc_done, busy, irq, pready, pslverr, pkt_dir, pkt_lock;
  logic [1:0]  lag = 0;
  logic [2:0]  pkt_size, sz [3] = '{3'h1, 3'h2, 3'h4};
  logic [6:0]  fc_sel;
  logic [7:0]  paddr = 0, ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [23:0] pkt_mem_addr, pkt_dev_addr;
  logic [31:0] pwdata = 0, prdata, r, b, c;
  logic [33:0] q [$], n;
  int          errors = 0, samples_checked = 0;
  int          nack = 0, ndone = 0;
  always #2 pclk = ~pclk;
  dac_channel i_dac_channel (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pkt_req, .pkt_ack, .pkt_mem_addr, .pkt_dev_addr, .pkt_size, .pkt_dir, .pkt_lock, .fc_sel,
    .fc_req, .fc_term, .fc_done, .busy, .irq);
  // one ordinary channel: flow control select (fc_sel) is left to software
  dac_partner i_dac_partner (.pclk, .presetn, .pkt_req, .lag, .pkt_ack);
  always @(posedge pclk)
    if (psel && penable && pready)
    begin
      n = q.pop_front();
      `CHK(pwrite ? {pslverr, 33'h0} : {pslverr, irq, prdata}, n)
    end
  // done pulses belong to hardware flow only, one per acked packet
  always @(posedge pclk)
  begin
    nack  += (pkt_req === 1'b1 && pkt_ack === 1'b1);
    ndone += (fc_done === 1'b1);
  end
  task automatic close_out(input bit t);
    errors += t;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (!pready && ++k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
      close_out(1);
    // an idle edge, so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {a > 8'h1C, 33'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, ei, d});
  endtask
  task automatic idle_wait();
    int k;
    k = 0;
    repeat (3) @(posedge pclk);
    while (busy !== 1'b0 && ++k < 500)
      @(posedge pclk);
    if (k == 500)
      close_out(1);
  endtask
  initial
    #100000 close_out(1);
  initial
  begin
    r = $urandom(90);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ofs[i])
      rd(ofs[i], 32'h0);
    wr(8'h20, 32'h1);
    // size 4 keeps the field legal while bit 23 is written high
    wr(8'h10, 32'hFCCF_FFFF);
    rd(8'h10, 32'h004F_FF00);
    repeat (3)
    begin
      r = $urandom;
      wr(8'h08, r);
      rd(8'h08, r & 32'h00FF_FFFF);
      wr(8'h0C, ~r);
      rd(8'h0C, ~r & 32'h00FF_FFFF);
    end
    $display("test registers done");
    wr(8'h18, 32'h1);
    foreach (sz[i])
    begin
      r = $urandom;
      b = r >> 9;
      c = r & 32'h007F_FFFF;
      lag <= i[1:0];
      wr(8'h04, b);
      wr(8'h0C, c);
      wr(8'h08, b + 3 * sz[i]);
      wr(8'h10, {7'h00, 2'b10, sz[i], 2'b10, i[0], 17'h10000});
      idle_wait();
      ei = 1'b1;
      rd(8'h04, b + 3 * sz[i]);
      rd(8'h0C, i[0] ? c + 3 * sz[i] : c);
      rd(8'h14, 32'h1);
      wr(8'h1C, 32'h7);
      ei = 1'b0;
      rd(8'h14, 32'h0);
    end
    $display("test firmware done");
    wr(8'h04, b);
    wr(8'h10, 32'h011A_0000);
    repeat (40) @(posedge pclk);
    rd(8'h10, 32'h011A_0020);
    wr(8'h10, 32'h021A_0000);
    @(posedge pclk);
    rd(8'h10, 32'h021A_0000);
    rd(8'h14, 32'h4);
    rd(8'h04, b);
    wr(8'h1C, 32'h7);
    `CHK(ndone, 0)
    $display("test abort done");
    wr(8'h08, 32'h00FF_FFFF);
    wr(8'h10, 32'h0017_7F00);
    `CHK({pkt_lock, pkt_dir, fc_sel, pkt_size}, {1'b1, 1'b1, 7'h3F, 3'h1})
    nack = 0;
    ndone = 0;
    fc_req <= 1'b1;
    repeat (20) @(posedge pclk);
    fc_req <= 1'b0;
    fc_term <= 1'b1;
    repeat (4) @(posedge pclk);
    fc_term <= 1'b0;
    idle_wait();
    rd(8'h14, 32'h2);
    `CHK(ndone, nack)
    `CHK(nack != 0, 1'b1)
    wr(8'h1C, 32'h7);
    wr(8'h10, 32'h0018_0000);
    fc_req <= 1'b1;
    repeat (10) @(posedge pclk);
    fc_req <= 1'b0;
    rd(8'h10, 32'h0018_0000);
    rd(8'h14, 32'h0);
    $display("test flow done");
    close_out(0);
  end
endmodule
